// ===== hw/sim_pkg.sv
/*
 * sim_pkg: register map, field layout, reset values and timing counts
 * for the system control unit (interrupt mask, status, bus timer).
 * assumes a single 250 MHz clock domain.
 */
package sim_pkg;
    // register offsets, byte addresses on the plain register port
    localparam logic [7:0] OFF_SYS_MASK  = 8'h00;
    localparam logic [7:0] OFF_BUS_MASK  = 8'h04;
    localparam logic [7:0] OFF_SYS_STAT  = 8'h08;
    localparam logic [7:0] OFF_BUS_STAT  = 8'h0C;
    localparam logic [7:0] OFF_SOFT_IRQ  = 8'h10;
    localparam logic [7:0] OFF_CTRL      = 8'h14;
    localparam logic [7:0] OFF_TOUT_STAT = 8'h18;

    localparam int unsigned LEVELS      = 7;
    localparam logic [6:0]  MASK_RST    = 7'h00;
    // control register: bit 0 clears the soft level 1 request
    localparam int unsigned CTRL_CLR1   = 0;
    // fixed priority slots
    localparam int unsigned LVL_SOFT    = 1;
    localparam int unsigned LVL_TIMER   = 3;
    localparam int unsigned LVL_VEC_A   = 5;
    localparam int unsigned LVL_VEC_B   = 6;
    localparam int unsigned LVL_FAIL    = 7;

    // bus timer
    localparam int unsigned CLK_MHZ     = 250;
    localparam int unsigned TOUT_US     = 16;
    localparam int unsigned TOUT_CYC    = TOUT_US * CLK_MHZ;
endpackage

// ===== hw/sim_irq_if.sv
/*
 * sim_irq_if: request bundle carried from the top to the priority encoder.
 * assumes the top drives requests and the encoder returns a level.
 */
`timescale 1ns/1ps
interface sim_irq_if;
    logic [7:1] req;
    logic [2:0] ipl;
    logic       any;

    modport src (output req, input ipl, input any);
    modport enc (input req, output ipl, output any);
endinterface

// ===== hw/sim_prio_enc.sv
/*
 * sim_prio_enc: picks the highest pending enabled level.
 * assumes requests are already masked.
 */
`timescale 1ns/1ps
module sim_prio_enc (
    sim_irq_if.enc b
);
    always_comb begin
        b.ipl = 3'h0;
        for (int i = 1; i <= 7; i++) begin
            if (b.req[i]) begin
                b.ipl = 3'(i);
            end
        end
        b.any = |b.req;
    end
endmodule

// ===== hw/sim_bus_timer.sv
/*
 * sim_bus_timer: counts the length of each processor bus cycle.
 * assumes cyc_act is high from cycle start until termination.
 */
`timescale 1ns/1ps
module sim_bus_timer #(
    parameter int unsigned LIMIT = sim_pkg::TOUT_CYC
) (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic cyc_act,
    output logic      expired
);
    initial begin
        if (LIMIT < 2 || LIMIT > 65535) begin
            $error("bus timer limit out of range");
        end
    end

    logic [15:0] cnt_q;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_q <= 16'h0000;
        end else if (ce) begin
            if (!cyc_act) begin
                cnt_q <= 16'h0000;
            end else if (cnt_q != 16'(LIMIT)) begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end

    // saturates at LIMIT so expired pulses only once per overlong cycle
    assign expired = (cnt_q == 16'(LIMIT - 1)) && cyc_act && ce;
endmodule

// ===== hw/sim_scu.sv
/*
 * sim_scu: system control unit. latches interrupt request levels from
 * on-board sources and expansion-bus cards, masks them, encodes the
 * processor priority, raises a soft level 1 and a bus-timeout level 3,
 * maps power fail to level 7 and times bus cycles for bus error.
 * assumes all inputs synchronous to mclk; ce freezes all state.
 */
// Operation
// - two mask registers gate on-board and expansion-bus requests
// - reset clears both mask registers, disabling every on-board and expansion-bus line
// - status register latches the seven request levels of each source
// - status shows raw lines, independent of the masks
// - write to a dedicated address raises autovectored level 1
// - only levels 5 and 6 are vectored, with acknowledge outputs
// - internal levels 1 and 3 fixed in priority, always autovectored
// - power fail gives level 7; otherwise only expansion cards
// - bus error when a bus cycle reaches 16 us
// - peripheral controller outputs enter as masked sources
`timescale 1ns/1ps
module sim_scu #(
    parameter int unsigned TOUT_CYC = sim_pkg::TOUT_CYC
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic [7:1]  sys_irq,
    input  wire logic [7:1]  bus_irq,
    input  wire logic        pwr_fail,
    input  wire logic        cyc_act,
    input  wire logic        interrupt_acknowledge_out_cycle,
    input  wire logic [2:0]  interrupt_acknowledge_out_level,
    output logic      [2:0]  ipl,
    output logic             bus_err,
    output logic             avec,
    output logic             interrupt_acknowledge_out_5,
    output logic             interrupt_acknowledge_out_6
);
    initial begin
        if (TOUT_CYC < 2 || TOUT_CYC > 65535) begin
            $error("timeout count out of range");
        end
    end

    logic [7:1] sys_mask_q;
    logic [7:1] bus_mask_q;
    logic [7:1] sys_stat_q;
    logic [7:1] bus_stat_q;
    logic       soft_q;
    logic       tout_q;
    logic       expired;

    sim_bus_timer #(
        .LIMIT   (TOUT_CYC)
    ) u_tmr (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .ce      (ce),
        .cyc_act (cyc_act),
        .expired (expired)
    );

    sim_irq_if irq ();
    sim_prio_enc u_enc (
        .b (irq)
    );

    // masks
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sys_mask_q <= sim_pkg::MASK_RST;
            bus_mask_q <= sim_pkg::MASK_RST;
        end else if (ce && reg_wr) begin
            if (reg_addr == sim_pkg::OFF_SYS_MASK) begin
                sys_mask_q <= reg_wdata[6:0];
            end
            if (reg_addr == sim_pkg::OFF_BUS_MASK) begin
                bus_mask_q <= reg_wdata[6:0];
            end
        end
    end

    // raw latched request levels; on-board set includes peripheral
    // controller outputs, so they pass the mask like any other line
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sys_stat_q <= 7'h00;
            bus_stat_q <= 7'h00;
        end else if (ce) begin
            sys_stat_q <= sys_irq;
            bus_stat_q <= bus_irq;
        end
    end

    // soft level 1: set by write, cleared by control; set wins
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            soft_q <= 1'b0;
        end else if (ce) begin
            if (reg_wr && reg_addr == sim_pkg::OFF_SOFT_IRQ) begin
                soft_q <= 1'b1;
            end else if (reg_wr && reg_addr == sim_pkg::OFF_CTRL
                         && reg_wdata[sim_pkg::CTRL_CLR1]) begin
                soft_q <= 1'b0;
            end
        end
    end

    // bus timeout flag drives the internal level 3; sticky until cleared
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tout_q <= 1'b0;
        end else if (ce) begin
            if (expired) begin
                tout_q <= 1'b1;
            end else if (reg_wr && reg_addr == sim_pkg::OFF_TOUT_STAT) begin
                tout_q <= 1'b0;
            end
        end
    end

    // bus error output held while the overlong cycle stays open
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bus_err <= 1'b0;
        end else if (ce) begin
            bus_err <= (expired || bus_err) && cyc_act;
        end
    end

    // masked request vector; level 7 from power fail bypasses masking
    // because a failing supply must never be hidden
    logic [7:1] sys_en;
    logic [7:1] bus_en;
    logic [7:1] req_all;
    always_comb begin
        sys_en  = sys_stat_q & sys_mask_q;
        bus_en  = bus_stat_q & bus_mask_q;
        req_all = bus_en;
        // on-board level 7 is not a legal source
        req_all[6:1] = req_all[6:1] | sys_en[6:1];
        req_all[sim_pkg::LVL_SOFT]  = req_all[1] | soft_q;
        req_all[sim_pkg::LVL_TIMER] = req_all[3] | tout_q;
        req_all[sim_pkg::LVL_FAIL]  = req_all[7] | pwr_fail;
    end
    assign irq.req = req_all;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ipl <= 3'h0;
        end else if (ce) begin
            ipl <= irq.ipl;
        end
    end

    // acknowledge: 5 and 6 vectored externally, all else autovectored
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            avec                        <= 1'b0;
            interrupt_acknowledge_out_5 <= 1'b0;
            interrupt_acknowledge_out_6 <= 1'b0;
        end else if (ce) begin
            interrupt_acknowledge_out_5 <= interrupt_acknowledge_out_cycle
                && interrupt_acknowledge_out_level == 3'(sim_pkg::LVL_VEC_A);
            interrupt_acknowledge_out_6 <= interrupt_acknowledge_out_cycle
                && interrupt_acknowledge_out_level == 3'(sim_pkg::LVL_VEC_B);
            avec <= interrupt_acknowledge_out_cycle && interrupt_acknowledge_out_level != 3'(sim_pkg::LVL_VEC_A)
                && interrupt_acknowledge_out_level != 3'(sim_pkg::LVL_VEC_B);
        end
    end

    // read port: data in the cycle after the strobe only
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (ce) begin
            reg_rdata <= 32'h0000_0000;
            if (reg_rd) begin
                unique case (reg_addr)
                    sim_pkg::OFF_SYS_MASK:  reg_rdata[6:0] <= sys_mask_q;
                    sim_pkg::OFF_BUS_MASK:  reg_rdata[6:0] <= bus_mask_q;
                    sim_pkg::OFF_SYS_STAT:  reg_rdata[6:0] <= sys_stat_q;
                    sim_pkg::OFF_BUS_STAT:  reg_rdata[6:0] <= bus_stat_q;
                    sim_pkg::OFF_SOFT_IRQ:  reg_rdata[0]   <= soft_q;
                    sim_pkg::OFF_TOUT_STAT: reg_rdata[0]   <= tout_q;
                    default:                reg_rdata      <= 32'h0000_0000;
                endcase
            end
        end
    end

    // checks
    property p_mask_reset;
        @(posedge mclk)
        !rst_n |=> sys_mask_q == 7'h00 && bus_mask_q == 7'h00;
    endproperty
    a_mask_reset: assert property (p_mask_reset)
        else $error("mask not cleared");

    property p_mask_hold;
        @(posedge mclk) disable iff (!rst_n)
        ce && !reg_wr |=> $stable(sys_mask_q) && $stable(bus_mask_q);
    endproperty
    a_mask_hold: assert property (p_mask_hold)
        else $error("mask moved without write");

    property p_stat_raw;
        @(posedge mclk) disable iff (!rst_n)
        ce |=> sys_stat_q == $past(sys_irq);
    endproperty
    a_stat_raw: assert property (p_stat_raw)
        else $error("status not raw");

    property p_bus_raw;
        @(posedge mclk) disable iff (!rst_n)
        ce |=> bus_stat_q == $past(bus_irq);
    endproperty
    a_bus_raw: assert property (p_bus_raw)
        else $error("bus status not raw");

    property p_stat_rd;
        @(posedge mclk) disable iff (!rst_n)
        ce && reg_rd && reg_addr == sim_pkg::OFF_SYS_STAT
        |=> reg_rdata[6:0] == $past(sys_stat_q);
    endproperty
    a_stat_rd: assert property (p_stat_rd)
        else $error("status read wrong");

    property p_soft_lvl;
        @(posedge mclk) disable iff (!rst_n)
        (ce && reg_wr && reg_addr == sim_pkg::OFF_SOFT_IRQ) ##1 ce
        |=> ipl != 3'h0;
    endproperty
    a_soft_lvl: assert property (p_soft_lvl)
        else $error("no level 1");

    property p_soft_clr;
        @(posedge mclk) disable iff (!rst_n)
        ce && reg_wr && reg_addr == sim_pkg::OFF_CTRL
        && reg_wdata[sim_pkg::CTRL_CLR1] |=> !soft_q;
    endproperty
    a_soft_clr: assert property (p_soft_clr)
        else $error("soft request not cleared");

    // power fail skips the status latch, so level 7 shows one cycle on
    property p_fail7;
        @(posedge mclk) disable iff (!rst_n)
        ce && pwr_fail |=> ipl == 3'h7;
    endproperty
    a_fail7: assert property (p_fail7)
        else $error("power fail not 7");

    property p_no_board7;
        @(posedge mclk) disable iff (!rst_n)
        ce && !pwr_fail && !bus_en[7] |=> ipl != 3'h7;
    endproperty
    a_no_board7: assert property (p_no_board7)
        else $error("level 7 from a board source");

    property p_masked;
        @(posedge mclk) disable iff (!rst_n)
        ce && !irq.any |=> ipl == 3'h0;
    endproperty
    a_masked: assert property (p_masked)
        else $error("ipl without request");

    property p_tout3;
        @(posedge mclk) disable iff (!rst_n)
        ce && tout_q && req_all[7:4] == 4'h0 |=> ipl == 3'h3;
    endproperty
    a_tout3: assert property (p_tout3)
        else $error("timeout not level 3");

    property p_berr;
        @(posedge mclk) disable iff (!rst_n)
        bus_err |-> $past(cyc_act);
    endproperty
    a_berr: assert property (p_berr)
        else $error("bus error off cycle");

    property p_berr_set;
        @(posedge mclk) disable iff (!rst_n)
        ce && expired |=> bus_err && tout_q;
    endproperty
    a_berr_set: assert property (p_berr_set)
        else $error("expiry without bus error");

    property p_vec;
        @(posedge mclk) disable iff (!rst_n)
        ce && interrupt_acknowledge_out_cycle && interrupt_acknowledge_out_level == 3'h5
        |=> interrupt_acknowledge_out_5 && !avec;
    endproperty
    a_vec: assert property (p_vec)
        else $error("level 5 not vectored");

    property p_vec6;
        @(posedge mclk) disable iff (!rst_n)
        ce && interrupt_acknowledge_out_cycle && interrupt_acknowledge_out_level == 3'h6
        |=> interrupt_acknowledge_out_6 && !avec;
    endproperty
    a_vec6: assert property (p_vec6)
        else $error("level 6 not vectored");

    property p_avec3;
        @(posedge mclk) disable iff (!rst_n)
        ce && interrupt_acknowledge_out_cycle && interrupt_acknowledge_out_level == 3'h3 |=> avec
        && !interrupt_acknowledge_out_5 && !interrupt_acknowledge_out_6;
    endproperty
    a_avec3: assert property (p_avec3)
        else $error("level 3 not auto");

    property p_avec1;
        @(posedge mclk) disable iff (!rst_n)
        ce && interrupt_acknowledge_out_cycle && interrupt_acknowledge_out_level == 3'h1 |=> avec
        && !interrupt_acknowledge_out_5 && !interrupt_acknowledge_out_6;
    endproperty
    a_avec1: assert property (p_avec1)
        else $error("level 1 not auto");

    property p_ack_idle;
        @(posedge mclk) disable iff (!rst_n)
        ce && !interrupt_acknowledge_out_cycle |=> !avec && !interrupt_acknowledge_out_5
        && !interrupt_acknowledge_out_6;
    endproperty
    a_ack_idle: assert property (p_ack_idle)
        else $error("acknowledge outside cycle");

    property p_freeze;
        @(posedge mclk) disable iff (!rst_n)
        !ce |=> $stable(ipl) && $stable(soft_q) && $stable(sys_mask_q);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while frozen");

    property p_rd_idle;
        @(posedge mclk) disable iff (!rst_n)
        ce && !reg_rd |=> reg_rdata == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data without read");

    c_soft:  cover property (@(posedge mclk) soft_q);
    c_berr:  cover property (@(posedge mclk) bus_err);
    c_fail:  cover property (@(posedge mclk) ipl == 3'h7);
    c_vec5:  cover property (@(posedge mclk) interrupt_acknowledge_out_5);
    c_tout:  cover property (@(posedge mclk) tout_q && ipl == 3'h3);
endmodule

// ===== sim/sim_cpu_model.sv
/*
 * sim_cpu_model: processor side of the system control unit: opens bus
 * cycles of a commanded length and runs acknowledge cycles.
 * assumes the bench pulses go_cyc and go_ack for one mclk cycle.
 */
`timescale 1ns/1ps
module sim_cpu_model (
    input  wire logic       mclk,
    input  wire logic       go_cyc,
    input  wire logic [7:0] cyc_len,
    input  wire logic       go_ack,
    input  wire logic [2:0] ack_lvl,
    output logic            cyc_act,
    output logic            interrupt_acknowledge_out_cycle,
    output logic [2:0]      interrupt_acknowledge_out_level
);
    logic [7:0] left_q = 8'h00;

    // a slow target is just a long count; the cycle stays open until then
    always @(posedge mclk) begin
        if (go_cyc) begin
            left_q <= cyc_len;
        end else if (left_q != 8'h00) begin
            left_q <= left_q - 8'h01;
        end
    end
    assign cyc_act = (left_q != 8'h00);

    initial begin
        interrupt_acknowledge_out_cycle = 1'b0;
        interrupt_acknowledge_out_level = 3'h0;
    end
    // level lines carry no meaning outside the cycle, so they keep moving
    always @(posedge mclk) begin
        interrupt_acknowledge_out_cycle <= go_ack;
        interrupt_acknowledge_out_level <= go_ack ? ack_lvl : ~interrupt_acknowledge_out_level;
    end
endmodule

// ===== sim/tb_top.sv
/*
 * tb_top: self-checking bench for the system control unit.
 * assumes a 250 MHz mclk and the shortened bus timer count of 20.
 */
`timescale 1ns/1ps
module tb_top;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ce = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [7:1]  sys_irq = 7'h00;
    logic [7:1]  bus_irq = 7'h00;
    logic        pwr_fail = 1'b0;
    logic        cyc_act, interrupt_acknowledge_out_cycle, bus_err, avec, ack5, ack6;
    logic [2:0]  interrupt_acknowledge_out_level, ipl;
    logic        go_cyc = 1'b0;
    logic        go_ack = 1'b0;
    logic [7:0]  cyc_len = 8'h00;
    logic [2:0]  ack_lvl = 3'h0;
    logic [31:0] rd;
    int          errors = 0;
    int          n_compared = 0;
    int          cycles = 0;

    always #2 mclk = ~mclk;

    sim_cpu_model CPU (.mclk(mclk), .go_cyc(go_cyc), .cyc_len(cyc_len),
        .go_ack(go_ack), .ack_lvl(ack_lvl), .cyc_act(cyc_act),
        .interrupt_acknowledge_out_cycle(interrupt_acknowledge_out_cycle), .interrupt_acknowledge_out_level(interrupt_acknowledge_out_level));

    sim_scu #(.TOUT_CYC(20)) DUT (.mclk(mclk), .rst_n(rst_n), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sys_irq(sys_irq),
        .bus_irq(bus_irq), .pwr_fail(pwr_fail), .cyc_act(cyc_act),
        .interrupt_acknowledge_out_cycle(interrupt_acknowledge_out_cycle), .interrupt_acknowledge_out_level(interrupt_acknowledge_out_level), .ipl(ipl),
        .bus_err(bus_err), .avec(avec),
        .interrupt_acknowledge_out_5(ack5),
        .interrupt_acknowledge_out_6(ack6));

    task automatic summarize;
        $display("errors=%0d compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask

    // request lines settle through status then encoder: two cycles
    task automatic irq(input logic [7:1] s, input logic [7:1] b,
                       input logic p);
        @(posedge mclk);
        sys_irq <= s;
        bus_irq <= b;
        pwr_fail <= p;
        wait_n(3);
    endtask

    task automatic t_reset;
        rdr(sim_pkg::OFF_SYS_MASK);
        chk(rd, 32'h0, "sys mask reset");
        rdr(sim_pkg::OFF_BUS_MASK);
        chk(rd, 32'h0, "bus mask reset");
        irq(7'h3F, 7'h7F, 1'b0);
        chk({29'h0, ipl}, 32'h0, "masked seen");
        rdr(sim_pkg::OFF_SYS_STAT);
        chk(rd, 32'h3F, "sys status");
        rdr(sim_pkg::OFF_BUS_STAT);
        chk(rd, 32'h7F, "bus status");
        rdr(8'h1C);
        chk(rd, 32'h0, "unmapped read");
    endtask

    task automatic t_mask;
        wr(sim_pkg::OFF_SYS_MASK, 32'h10);
        irq(7'h10, 7'h20, 1'b0);
        chk({29'h0, ipl}, 32'h5, "ipl 5");
        wr(sim_pkg::OFF_BUS_MASK, 32'h20);
        wait_n(3);
        chk({29'h0, ipl}, 32'h6, "ipl 6");
        wr(sim_pkg::OFF_BUS_MASK, 32'h0);
        irq(7'h13, 7'h20, 1'b0);
        chk({29'h0, ipl}, 32'h5, "mask gate");
        rdr(sim_pkg::OFF_SYS_STAT);
        chk(rd, 32'h13, "raw status");
        wr(sim_pkg::OFF_SYS_MASK, 32'h0);
        irq(7'h00, 7'h00, 1'b0);
        chk({29'h0, ipl}, 32'h0, "none pending");
    endtask

    task automatic t_soft;
        wr(sim_pkg::OFF_SOFT_IRQ, 32'h1);
        wait_n(2);
        chk({29'h0, ipl}, 32'h1, "soft level");
        wr(sim_pkg::OFF_CTRL, 32'h1);
        wait_n(3);
        chk({29'h0, ipl}, 32'h0, "soft cleared");
    endtask

    task automatic t_fail;
        wr(sim_pkg::OFF_SYS_MASK, 32'h7F);
        irq(7'h40, 7'h00, 1'b0);
        chk({29'h0, ipl}, 32'h0, "board level 7");
        wr(sim_pkg::OFF_SYS_MASK, 32'h0);
        irq(7'h00, 7'h00, 1'b1);
        chk({29'h0, ipl}, 32'h7, "power fail");
        wr(sim_pkg::OFF_BUS_MASK, 32'h40);
        irq(7'h00, 7'h40, 1'b0);
        chk({29'h0, ipl}, 32'h7, "card level 7");
        wr(sim_pkg::OFF_BUS_MASK, 32'h0);
        irq(7'h00, 7'h00, 1'b0);
    endtask

    // open a bus cycle and gather any bus error seen while it runs
    task automatic bus_cyc(input logic [7:0] n, output logic seen);
        seen = 1'b0;
        @(posedge mclk);
        cyc_len <= n;
        go_cyc <= 1'b1;
        @(posedge mclk);
        go_cyc <= 1'b0;
        repeat (int'(n) + 3) begin
            @(posedge mclk);
            #1 seen = seen | bus_err;
        end
    endtask

    task automatic t_timer;
        logic s;
        bus_cyc(8'd12, s);
        chk({31'h0, s}, 32'h0, "prompt cycle");
        // one short of and one past the count of 20
        bus_cyc(8'd19, s);
        chk({31'h0, s}, 32'h0, "cycle just in time");
        bus_cyc(8'd21, s);
        chk({31'h0, s}, 32'h1, "cycle just too long");
        bus_cyc(8'd30, s);
        chk({31'h0, s}, 32'h1, "overlong cycle");
        chk({31'h0, bus_err}, 32'h0, "error ends");
        chk({29'h0, ipl}, 32'h3, "timeout level");
        rdr(sim_pkg::OFF_TOUT_STAT);
        chk(rd, 32'h1, "timeout flag");
        wr(sim_pkg::OFF_TOUT_STAT, 32'h0);
        wait_n(3);
        chk({29'h0, ipl}, 32'h0, "timeout cleared");
    endtask

    task automatic t_ack;
        logic [2:0] s;
        logic [2:0] e;
        for (int l = 1; l < 8; l++) begin
            s = 3'h0;
            @(posedge mclk);
            ack_lvl <= 3'(l);
            go_ack <= 1'b1;
            @(posedge mclk);
            go_ack <= 1'b0;
            repeat (4) begin
                @(posedge mclk);
                #1 s = s | {avec, ack6, ack5};
            end
            e = {l != 5 && l != 6, l == 6, l == 5};
            chk({29'h0, s}, {29'h0, e}, "ack kind");
        end
    endtask

    // with ce low the soft request write must be lost
    task automatic t_freeze;
        @(posedge mclk);
        ce <= 1'b0;
        wr(sim_pkg::OFF_SOFT_IRQ, 32'h1);
        wait_n(3);
        chk({29'h0, ipl}, 32'h0, "frozen write");
        @(posedge mclk);
        ce <= 1'b1;
        rdr(sim_pkg::OFF_SOFT_IRQ);
        chk(rd, 32'h0, "frozen flag");
    endtask

    // a second reset in mid-run must clear masks written before it
    task automatic t_rst2;
        wr(sim_pkg::OFF_SYS_MASK, 32'h7F);
        wr(sim_pkg::OFF_BUS_MASK, 32'h7F);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        rdr(sim_pkg::OFF_SYS_MASK);
        chk(rd, 32'h0, "sys mask rearm");
        rdr(sim_pkg::OFF_BUS_MASK);
        chk(rd, 32'h0, "bus mask rearm");
    endtask

    // far above the few hundred cycles the sequence needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            summarize();
        end
    end

    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_mask();
        t_soft();
        t_freeze();
        t_fail();
        t_timer();
        t_ack();
        t_rst2();
        summarize();
    end
endmodule
